// [design/dbam_pkg.sv]
// shared types and constants for the dram bank address mapper
package dbam_pkg;
   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   localparam int PHYS_AW = 31;
   localparam int SPACE_HI = 30;
   localparam int SPACE_LO = 28;
   localparam logic [2:0] SYSTEM_MEMORY_SPACE = 3'h0;
   localparam int BANK_HI = 27;
   localparam int BANK_LO = 25;
   localparam int WORD_SEL_BIT = 2;
   localparam int NUM_BANKS = 8;
   localparam int MUX_AW = 12;
   localparam logic [7:0] EVEN_BANKS = 8'h55;
   localparam logic [7:0] ODD_BANKS = 8'haa;
   localparam logic [7:0] ALL_BANKS = 8'hff;
   // ----------------------------------------------------------------
   // data and merge fields
   // ----------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam logic [31:0] BYTE_MASK = 32'h000000ff;
   localparam logic [31:0] HALF_MASK = 32'h0000ffff;
   // ----------------------------------------------------------------
   // timing in processor clocks; page limit in column accesses, fifo depth in entries
   // ----------------------------------------------------------------
   localparam logic [1:0] T_PRECHARGE_CYC = 2'h2;
   localparam logic [1:0] T_ROW_TO_COL_CYC = 2'h2;
   localparam logic [1:0] T_COL_PULSE_CYC = 2'h2;
   localparam logic [10:0] PAGE_MAX_CYCLES = 11'h400;
   localparam int FIFO_DEPTH = 16;
   // ----------------------------------------------------------------
   // request and response carriers
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      K_RD_WORD, K_RD_DWORD, K_WR_WORD, K_WR_DWORD, K_WR_HALF, K_WR_BYTE
   } dbam_kind_e;
   typedef struct packed {
      logic [30:0] phys_addr;
      dbam_kind_e kind;
      logic [63:0] wdata;
   } dbam_req_s;
   typedef struct packed {
      logic [63:0] rdata;
      logic parity_err;
   } dbam_rsp_s;
endpackage

// [design/dbam_mapper.sv]
// dram bank address mapper: request fifo, decode, strobe sequencer
//
// Functional notes
// [RULE1] only address space zero reaches memory
// [RULE2] eight active-low row strobes, 32 MB banks
// [RULE3] address bits 27-25 pick one row strobe
// [RULE4] even banks strobes 1:0, odd 3:2
// [RULE5] bit 2 picks word within strobe pair
// [RULE6] shared active-low write and output enables
// [RULE7] one shared 12-bit multiplexed address bus
// [RULE8] row bits from 20-12, 22, 24, 23
// [RULE9] column bits from 11-3 and 21
// [RULE10] bit 23 is column 10, row 11
// [RULE11] bits 1-0 only select merge field
// [RULE12] byte/halfword stores become read-modify-write
// [RULE13] small banks alias onto lowest locations silently
// [RULE14] empty bank reads may flag parity error
// [RULE15] dual mode: even+odd open, bit 25 qualifies
// [RULE16] single mode: one row strobe, pairs identical
// [RULE17] board straps mode; dual only fast-page
// [RULE18] page mode up to 1024 cycles per page
// [RULE19] dual mode keeps two open-page trackers
// [RULE20] decode ignores bits 30-28 after acceptance
// [RULE21] board fits 64 data bits plus parity
// [RULE22] polarity select: 0 even, 1 odd parity
// [RULE23] parity bit 0 covers 31:0, 1 covers 63:32
// [RULE24] row address before row strobe, column before column strobe
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------------------------------
// request fifo
// --------------------------------------------------------------------
module dbam_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] count_q, count_d;
   logic ready_q;
   wire push = i_in_valid && ready_q;
   wire pop = i_out_ready && (count_q != '0);
   assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
   assign o_in_ready = ready_q;
   assign o_out_valid = (count_q != '0);
   assign o_out_data = mem[rd_q];
   always_ff @(posedge i_clock) begin
      if (push) mem[wr_q] <= i_in_data;
   end
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
         ready_q <= 1'b0;
      end else begin
         wr_q <= wr_q + AW'(push);
         rd_q <= rd_q + AW'(pop);
         count_q <= count_d;
         ready_q <= (count_d != (AW+1)'(DEPTH));
      end
   end
endmodule // dbam_fifo

// --------------------------------------------------------------------
// top: mapper and strobe sequencer
// --------------------------------------------------------------------
module dbam_mapper (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire dbam_pkg::dbam_req_s i_req,
   output logic o_rsp_valid,
   output dbam_pkg::dbam_rsp_s o_rsp,
   input wire logic i_module_mode_strap,
   input wire logic i_parity_polarity_sel,
   output logic [7:0] o_ras_n,
   output logic [3:0] o_cas_n,
   output logic o_mem_write_en_n,
   output logic o_mem_out_en_n,
   output logic [11:0] o_dram_mux_addr,
   input wire logic [63:0] i_mem_data,
   output logic [63:0] o_mem_data,
   output logic o_mem_data_oe,
   input wire logic [1:0] i_dram_parity_bits,
   output logic [1:0] o_dram_parity_bits,
   output logic o_dram_parity_oe
);
   import dbam_pkg::*;

   typedef enum {S_IDLE, S_EVAL, S_CLOSE, S_ROW, S_RAS, S_COL, S_CAS, S_MERGE, S_DONE}
      dbam_state_e;

   // ----------------------------------------------------------------
   // fifo in the request path
   // ----------------------------------------------------------------
   dbam_req_s fifo_out;
   logic fifo_valid;
   dbam_state_e state_q;
   wire fifo_pop = (state_q == S_IDLE);
   dbam_fifo #(.WIDTH($bits(dbam_req_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_in_valid(i_req_valid),
      .o_in_ready(o_req_ready),
      .i_in_data(i_req),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_out)
   );

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   dbam_req_s cur_q;
   logic [1:0] wait_q;
   logic rmw_wr_q;
   logic [63:0] rd_q;
   logic open_q [2];
   logic [2:0] obank_q [2];
   logic [11:0] orow_q [2];
   logic [10:0] page_cnt_q [2];
   logic [7:0] ras_n_q;
   logic [3:0] cas_n_q;
   logic [11:0] addr_q;

   // space bits are dropped past acceptance
   wire [27:0] ma = cur_q.phys_addr[27:0]; // RULE20
   wire [2:0] bank = ma[BANK_HI:BANK_LO]; // RULE3
   wire dual = !i_module_mode_strap;
   wire grp = dual & ma[BANK_LO]; // RULE19
   // no size compare: unfitted high bits fall outside the part and alias
   wire [11:0] row_w = {ma[23], ma[24], ma[22], ma[20:12]}; // RULE8 RULE10 RULE13
   wire [11:0] col_w = {1'b0, ma[23], ma[21], ma[11:3]}; // RULE9 RULE10 RULE11
   wire [7:0] bank_sel = 8'h01 << bank; // RULE2 RULE3
   wire wide = (cur_q.kind == K_RD_DWORD) || (cur_q.kind == K_WR_DWORD);
   wire part = (cur_q.kind == K_WR_HALF) || (cur_q.kind == K_WR_BYTE);
   wire is_wr = (cur_q.kind != K_RD_WORD) && (cur_q.kind != K_RD_DWORD);
   wire wr_phase = is_wr && (!part || rmw_wr_q); // RULE12
   // bit 0 of pair: lower word (63:32), bit 1: higher word (31:0)
   wire [1:0] pair = wide ? 2'h3 : (ma[WORD_SEL_BIT] ? 2'h2 : 2'h1); // RULE5
   wire [3:0] cas_sel = !dual ? {pair, pair} // RULE16
                      : (ma[BANK_LO] ? {pair, 2'h0} : {2'h0, pair}); // RULE4 RULE15
   wire hit = open_q[grp] && (obank_q[grp] == bank) && (orow_q[grp] == row_w)
              && (page_cnt_q[grp] < PAGE_MAX_CYCLES); // RULE18 RULE19
   wire [7:0] close_mask = !dual ? ALL_BANKS : (grp ? ODD_BANKS : EVEN_BANKS); // RULE16

   // ----------------------------------------------------------------
   // merge for partial stores
   // ----------------------------------------------------------------
   wire [31:0] rd_word = ma[WORD_SEL_BIT] ? rd_q[31:0] : rd_q[63:32];
   wire [4:0] sh = (cur_q.kind == K_WR_BYTE) ? {~ma[1:0], 3'h0} : {~ma[1], 4'h0};
   wire [31:0] fmask = ((cur_q.kind == K_WR_BYTE) ? BYTE_MASK : HALF_MASK) << sh;
   wire [31:0] merged = (rd_word & ~fmask) | ((cur_q.wdata[31:0] << sh) & fmask); // RULE11
   wire [63:0] wdata = wide ? cur_q.wdata : {2{cur_q.wdata[31:0]}};
   wire [1:0] wpar = {^wdata[63:32], ^wdata[31:0]} ^ {2{i_parity_polarity_sel}}; // RULE22 RULE23
   wire [1:0] rchk = ({^i_mem_data[63:32], ^i_mem_data[31:0]}
                      ^ {2{i_parity_polarity_sel}} ^ i_dram_parity_bits)
                      & {pair[0], pair[1]}; // RULE14 RULE23
   // lower word lane (63:32) against parity bit 1, for the lane check below
   wire low_lane_bad = ^{i_mem_data[63:32], i_dram_parity_bits[1], i_parity_polarity_sel};

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   dbam_state_e state_d;
   wire wait_done = (state_q == S_CLOSE) ? (wait_q == T_PRECHARGE_CYC - 2'h1)
                  : (state_q == S_RAS) ? (wait_q == T_ROW_TO_COL_CYC - 2'h1)
                  : (wait_q == T_COL_PULSE_CYC - 2'h1);
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (fifo_valid && fifo_out.phys_addr[SPACE_HI:SPACE_LO] == SYSTEM_MEMORY_SPACE) begin
               state_d = S_EVAL; // RULE1
            end
         end
         S_EVAL: state_d = hit ? S_COL : S_CLOSE; // RULE18
         S_CLOSE: if (wait_done) state_d = S_ROW;
         S_ROW: state_d = S_RAS;
         S_RAS: if (wait_done) state_d = S_COL;
         S_COL: state_d = S_CAS;
         S_CAS: begin
            if (wait_done) state_d = (part && !rmw_wr_q) ? S_MERGE : S_DONE; // RULE12
         end
         S_MERGE: state_d = S_COL;
         S_DONE: state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q <= S_IDLE;
         cur_q <= '0;
         wait_q <= '0;
      end else begin
         state_q <= state_d;
         if (fifo_pop && fifo_valid) cur_q <= fifo_out;
         if (state_q == S_MERGE) cur_q.wdata <= {2{merged}};
         wait_q <= (state_d != state_q) ? 2'h0 : wait_q + 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // open-page trackers, one per bank group
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_track
      always_ff @(posedge i_clock or posedge i_rst) begin
         if (i_rst) begin
            open_q[g] <= 1'b0;
            obank_q[g] <= '0;
            orow_q[g] <= '0;
            page_cnt_q[g] <= '0;
         end else if (state_q == S_CLOSE && (!dual || grp == 1'(g))) begin
            open_q[g] <= 1'b0; // RULE16 RULE19
         end else if (state_q == S_ROW && grp == 1'(g)) begin
            open_q[g] <= 1'b1;
            obank_q[g] <= bank;
            orow_q[g] <= row_w;
            page_cnt_q[g] <= '0;
         end else if (state_q == S_COL && grp == 1'(g)) begin
            page_cnt_q[g] <= page_cnt_q[g] + 11'h1; // RULE18
         end
      end
   end

   // ----------------------------------------------------------------
   // dram pins, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ras_n_q <= ALL_BANKS;
         cas_n_q <= 4'hf;
         addr_q <= '0;
         o_mem_write_en_n <= 1'b1;
         o_mem_out_en_n <= 1'b1;
         o_mem_data <= '0;
         o_mem_data_oe <= 1'b0;
         o_dram_parity_bits <= '0;
         o_dram_parity_oe <= 1'b0;
         rmw_wr_q <= 1'b0;
         rd_q <= '0;
         o_rsp_valid <= 1'b0;
         o_rsp <= '0;
      end else begin
         o_rsp_valid <= (state_q == S_DONE);
         case (state_q)
            S_CLOSE: begin
               // row address settles two cycles ahead of the row strobe
               addr_q <= row_w; // RULE24
               ras_n_q <= ras_n_q | close_mask; // RULE16
            end
            S_ROW: begin
               addr_q <= row_w; // RULE7 RULE24
               ras_n_q <= ras_n_q & ~bank_sel; // RULE2 RULE15
            end
            S_RAS: if (wait_done) addr_q <= col_w; // RULE24
            S_COL: begin
               cas_n_q <= ~cas_sel; // RULE4 RULE24
               o_mem_write_en_n <= !wr_phase; // RULE6
               o_mem_out_en_n <= wr_phase; // RULE6
               o_mem_data_oe <= wr_phase;
               o_dram_parity_oe <= wr_phase;
               o_mem_data <= wdata;
               o_dram_parity_bits <= wpar; // RULE22 RULE23
            end
            S_CAS: begin
               if (wait_done) begin
                  cas_n_q <= 4'hf;
                  if (!wr_phase) begin
                     rd_q <= i_mem_data;
                     o_rsp.rdata <= i_mem_data;
                     o_rsp.parity_err <= |rchk; // RULE14
                  end
               end
            end
            S_MERGE: begin
               rmw_wr_q <= 1'b1; // RULE12
               o_mem_out_en_n <= 1'b1;
            end
            S_DONE: begin
               rmw_wr_q <= 1'b0;
               o_mem_write_en_n <= 1'b1;
               o_mem_out_en_n <= 1'b1;
               o_mem_data_oe <= 1'b0;
               o_dram_parity_oe <= 1'b0;
            end
            S_EVAL: if (hit) addr_q <= col_w;
            default: ;
         endcase
      end
   end
   assign o_ras_n = ras_n_q;
   assign o_cas_n = cas_n_q;
   assign o_dram_mux_addr = addr_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_single_one_row: assert property (@(posedge i_clock) disable iff (i_rst) // RULE16
      !dual |-> $countones(~ras_n_q) <= 1) else $error("two row strobes in single mode");
   a_dual_group_rows: assert property (@(posedge i_clock) disable iff (i_rst) // RULE15
      dual |-> ($countones(~ras_n_q & EVEN_BANKS) <= 1) && ($countones(~ras_n_q & ODD_BANKS) <= 1))
      else $error("two row strobes in one group");
   a_single_pairs_same: assert property (@(posedge i_clock) disable iff (i_rst) // RULE16
      !dual |-> cas_n_q[3:2] == cas_n_q[1:0]) else $error("column pairs differ");
   a_dual_pair_qual: assert property (@(posedge i_clock) disable iff (i_rst) // RULE15
      (dual && cas_n_q[1:0] != 2'h3) |-> !ma[BANK_LO] && cas_n_q[3:2] == 2'h3)
      else $error("even pair on odd bank");
   a_row_before_strobe: assert property (@(posedge i_clock) disable iff (i_rst) // RULE24
      (state_q == S_RAS && $past(state_q) == S_ROW)
      |-> $past(addr_q) == row_w && addr_q == row_w && !ras_n_q[bank])
      else $error("row strobe without row address");
   a_col_before_strobe: assert property (@(posedge i_clock) disable iff (i_rst) // RULE24
      (cas_n_q != 4'hf && $past(cas_n_q) == 4'hf) |-> $past(addr_q) == col_w && addr_q == col_w)
      else $error("column strobe without column address");
   a_rmw_read_first: assert property (@(posedge i_clock) disable iff (i_rst) // RULE12
      (state_q == S_MERGE) |=> state_q == S_COL ##1 !o_mem_write_en_n && cas_n_q != 4'hf)
      else $error("merge not followed by write");
   a_parity_out: assert property (@(posedge i_clock) disable iff (i_rst) // RULE22
      o_dram_parity_oe |-> o_dram_parity_bits == ({^o_mem_data[63:32], ^o_mem_data[31:0]}
      ^ {2{$past(i_parity_polarity_sel)}})) else $error("parity out wrong");
   a_page_limit: assert property (@(posedge i_clock) disable iff (i_rst) // RULE18
      page_cnt_q[0] <= PAGE_MAX_CYCLES && page_cnt_q[1] <= PAGE_MAX_CYCLES)
      else $error("page run too long");
   a_space_zero: assert property (@(posedge i_clock) disable iff (i_rst) // RULE1
      (state_q == S_EVAL) |-> cur_q.phys_addr[SPACE_HI:SPACE_LO] == SYSTEM_MEMORY_SPACE)
      else $error("non-memory request reached decode");
   a_enables_excl: assert property (@(posedge i_clock) disable iff (i_rst) // RULE6
      !(!o_mem_write_en_n && !o_mem_out_en_n)) else $error("write and output enable both low");
   a_read_lane_par: assert property (@(posedge i_clock) disable iff (i_rst) // RULE23
      (state_q == S_CAS && wait_done && !wr_phase && pair == 2'h1)
      |=> o_rsp.parity_err == $past(low_lane_bad)) else $error("read parity on wrong lane");
endmodule // dbam_mapper

`default_nettype wire

// [bench/dbam_dram_model.sv]
// behavioural model of the eight dram banks behind the mapper
`timescale 1ns/1ns
`default_nettype none
module dbam_dram_model (
   input wire logic i_clock,
   input wire logic [7:0] i_ras_n,
   input wire logic [3:0] i_cas_n,
   input wire logic i_we_n,
   input wire logic i_oe_n,
   input wire logic [11:0] i_addr,
   input wire logic [63:0] i_data,
   input wire logic i_data_oe,
   input wire logic [1:0] i_par,
   input wire logic [7:0] i_small_banks,
   output logic [63:0] o_data,
   output logic [1:0] o_par,
   output logic [11:0] o_col,
   output logic [1:0] o_wpar
);
   // one word lane plus its parity bit per entry
   logic [32:0] mem [logic [27:0]];
   logic [11:0] row_q [8];
   logic [7:0] ras_prev = 8'hff;
   logic [3:0] cas_prev = 4'hf;
   initial begin
      o_data = 64'h0;
      o_par = 2'h0;
   end
   // pair 0 serves even banks, pair 1 odd; single mode has only one open bank
   function automatic logic [27:0] key(input int k);
      int b;
      logic [11:0] m;
      b = 0;
      for (int i = 0; i < 8; i++) if (!i_ras_n[i]) b = i;
      for (int i = 0; i < 8; i++) if (!i_ras_n[i] && i % 2 == k / 2) b = i;
      m = i_small_banks[b] ? 12'h3ff : 12'hfff;
      return {b[2:0], row_q[b] & m, o_col & m, k[0]};
   endfunction
   // sampled mid-cycle, where the registered strobes have settled
   always @(negedge i_clock) begin
      for (int i = 0; i < 8; i++) if (!i_ras_n[i] && ras_prev[i]) row_q[i] = i_addr;
      if (|(cas_prev & ~i_cas_n)) o_col = i_addr;
      for (int k = 0; k < 4; k++) begin
         if (!i_cas_n[k] && !i_we_n && i_data_oe) begin
            mem[key(k)] = {i_par[1 - k % 2], i_data[32 * (1 - k % 2) +: 32]};
            o_wpar[1 - k % 2] = i_par[1 - k % 2];
         end
      end
      if (!i_oe_n && i_we_n && i_cas_n != 4'hf) begin
         for (int k = 0; k < 4; k++) begin
            if (!i_cas_n[k]) begin
               // unwritten cells read as zero with a bad even parity bit
               {o_par[1 - k % 2], o_data[32 * (1 - k % 2) +: 32]} =
                  mem.exists(key(k)) ? mem[key(k)] : 33'h1_0000_0000;
            end
         end
      end else begin
         // released bus: never leave the last value standing
         o_data = ~o_data;
         o_par = ~o_par;
      end
      ras_prev = i_ras_n;
      cas_prev = i_cas_n;
   end
endmodule // dbam_dram_model
`default_nettype wire

// [bench/tb_dbam_mapper.sv]
// self-checking bench for the dram bank address mapper
`timescale 1ns/1ns
`default_nettype none
module tb_dbam_mapper;
   import dbam_pkg::*;
   logic i_clock, i_rst, i_req_valid, strap, psel, we_n, oe_n, data_oe, o_req_ready, o_rsp_valid;
   logic full_seen, last_perr, par_oe;
   dbam_req_s i_req;
   dbam_rsp_s o_rsp;
   logic [7:0] ras_n;
   logic [3:0] cas_n, cas_acc;
   logic [11:0] maddr, col;
   logic [63:0] rd_bus, wr_bus, last_rdata;
   logic [1:0] rd_par, wr_par, wpar;
   int mismatches = 0, checks_done = 0, rsp_count = 0;
   dbam_mapper u_dbam_mapper (.i_clock(i_clock), .i_rst(i_rst), .i_req_valid(i_req_valid),
      .o_req_ready(o_req_ready), .i_req(i_req), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp),
      .i_module_mode_strap(strap), .i_parity_polarity_sel(psel), .o_ras_n(ras_n),
      .o_cas_n(cas_n), .o_mem_write_en_n(we_n), .o_mem_out_en_n(oe_n),
      .o_dram_mux_addr(maddr), .i_mem_data(rd_bus), .o_mem_data(wr_bus),
      .o_mem_data_oe(data_oe), .i_dram_parity_bits(rd_par), .o_dram_parity_bits(wr_par),
      .o_dram_parity_oe(par_oe));
   dbam_dram_model u_dbam_dram_model (.i_clock(i_clock), .i_ras_n(ras_n), .i_cas_n(cas_n),
      .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(maddr), .i_data(wr_bus),
      .i_data_oe(data_oe & par_oe),
      .i_par(wr_par), .i_small_banks(8'h02), .o_data(rd_bus), .o_par(rd_par), .o_col(col),
      .o_wpar(wpar));
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   always @(negedge i_clock) begin
      cas_acc = cas_acc | ~cas_n;
      if (o_req_ready === 1'b0 && i_rst === 1'b0) full_seen = 1'b1;
      if (o_rsp_valid === 1'b1) begin
         rsp_count++;
         last_rdata = o_rsp.rdata;
         last_perr = o_rsp.parity_err;
      end
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // strap only moves under reset, as a board would wire it
   task automatic do_reset(input logic s);
      i_rst <= 1'b1;
      strap <= s;
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clock);
   endtask
   // called at a rising edge; leaves valid up when more follow
   task automatic send(input logic [30:0] pa, input dbam_kind_e k, input logic [63:0] wd,
                       input bit last);
      i_req_valid <= 1'b1;
      i_req <= '{phys_addr: pa, kind: k, wdata: wd};
      do @(negedge i_clock); while (o_req_ready !== 1'b1);
      @(posedge i_clock);
      if (last) i_req_valid <= 1'b0;
   endtask
   task automatic wait_rsp(input int n);
      int t;
      t = 0;
      while (rsp_count < n && t < 600) begin
         @(posedge i_clock);
         t++;
      end
      chk(64'(rsp_count), 64'(n), "response count");
   endtask
   task automatic acc(input logic [30:0] pa, input dbam_kind_e k, input logic [63:0] wd);
      logic [1:0] ln;
      ln = (k == K_RD_DWORD || k == K_WR_DWORD) ? 2'b11 : (pa[2] ? 2'b10 : 2'b01);
      cas_acc = 4'h0;
      send(pa, k, wd, 1'b1);
      wait_rsp(rsp_count + 1);
      chk(cas_acc, strap ? {ln, ln} : (pa[25] ? {ln, 2'h0} : {2'h0, ln}), "cas");
      chk(ras_n[pa[27:25]], 0, "bank row strobe");
      chk(u_dbam_dram_model.row_q[pa[27:25]], {pa[23], pa[24], pa[22], pa[20:12]}, "row");
      chk(col, {1'b0, pa[23], pa[21], pa[11:3]}, "column");
      if (strap) chk(64'($countones(~ras_n)), 1, "open banks");
   endtask
   task automatic rd_word(input logic [30:0] pa, input logic [31:0] exp, input logic perr);
      acc(pa, K_RD_WORD, 64'h0);
      chk(pa[2] ? last_rdata[31:0] : last_rdata[63:32], exp, "read word");
      chk(last_perr, perr, "parity flag");
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_idle_drop();
      chk({ras_n, cas_n, we_n, oe_n}, 14'h3fff, "idle strobes");
      send(31'h2000_0040, K_WR_WORD, 64'h1, 1'b1);
      repeat (40) @(posedge i_clock);
      chk(64'(rsp_count), 0, "foreign space answered");
      chk(ras_n, 8'hff, "foreign space opened a bank");
   endtask
   task automatic t_banks();
      logic [30:0] pa;
      for (int b = 0; b < 8; b++) begin
         pa = {3'h0, 3'(b), 12'h5a3, b[0], 9'h0c3, b[1], 2'h0};
         acc(pa, K_WR_WORD, 64'(32'hc0de_0000 + b));
         rd_word(pa, 32'hc0de_0000 + b, 1'b0);
      end
      acc(31'h0800_0a38, K_WR_DWORD, 64'h0123_4567_89ab_cdef);
      acc(31'h0800_0a38, K_RD_DWORD, 64'h0);
      chk(last_rdata, 64'h0123_4567_89ab_cdef, "dword");
   endtask
   task automatic t_rmw();
      logic [31:0] e;
      e = 32'h1122_3344;
      acc(31'h0431_5670, K_WR_WORD, 64'(e));
      for (int o = 0; o < 4; o++) begin
         acc({29'h010c_559c, 2'(o)}, K_WR_BYTE, 64'(8'ha0 + o));
         e[24 - 8 * o +: 8] = 8'(8'ha0 + o);
      end
      acc(31'h0431_5672, K_WR_HALF, 64'h0000_beef);
      e[15:0] = 16'hbeef;
      rd_word(31'h0431_5670, e, 1'b0);
   endtask
   task automatic t_parity();
      for (int p = 0; p < 2; p++) begin
         psel <= 1'(p);
         acc(31'h0c00_1100, K_WR_DWORD, 64'h0000_0001_0000_0003);
         chk(wpar, {1'b1 ^ 1'(p), 1'(p)}, "written parity");
         rd_word(31'h0c00_1100, 32'h1, 1'b0);
      end
      psel <= 1'b0;
      rd_word(31'h0c00_1100, 32'h1, 1'b1);
      rd_word(31'h0bff_fff8, 32'h0, 1'b1);
   endtask
   task automatic t_alias_dual();
      acc(31'h0200_2008, K_WR_WORD, 64'h5eed_f00d);
      rd_word(31'h0280_2008, 32'h5eed_f00d, 1'b0);
      rd_word(31'h0300_2008, 32'h5eed_f00d, 1'b0);
      acc(31'h0000_4000, K_WR_WORD, 64'h77);
      rd_word(31'h0200_2008, 32'h5eed_f00d, 1'b0);
      chk(ras_n[1:0], 2'h0, "even and odd open");
      rd_word(31'h0000_4000, 32'h77, 1'b0);
   endtask
   task automatic t_fill();
      int n;
      n = rsp_count;
      full_seen = 1'b0;
      for (int i = 0; i < 28; i++) send(31'h0a00_0000 + 31'(4 * i), K_WR_WORD, 64'(i), i == 27);
      wait_rsp(n + 28);
      chk(full_seen, 1'b1, "queue never refused");
      rd_word(31'h0a00_0000, 32'h0, 1'b0);
      rd_word(31'h0a00_006c, 32'd27, 1'b0);
   endtask
   task automatic t_single();
      rd_word(31'h0000_4000, 32'h77, 1'b0);
      acc(31'h0200_2008, K_WR_WORD, 64'h1234);
      rd_word(31'h0000_4000, 32'h77, 1'b0);
   endtask
   initial begin
      i_rst = 1'b1;
      i_req_valid = 1'b0;
      i_req = '0;
      strap = 1'b0;
      psel = 1'b0;
      cas_acc = 4'h0;
      full_seen = 1'b0;
      do_reset(1'b0);
      t_idle_drop();
      t_banks();
      t_rmw();
      t_parity();
      t_alias_dual();
      t_fill();
      do_reset(1'b1);
      t_single();
      give_verdict();
   end
   // roughly seventy accesses of under a hundred cycles each
   initial begin
      repeat (20000) @(posedge i_clock);
      mismatches++;
      give_verdict();
   end
endmodule // tb_dbam_mapper
`default_nettype wire
